/* File: hdl/phy_diag_pkg.sv */
package phy_diag_pkg;

  // ****************************************************************
  // Register indices (one 16-bit register per index)
  // ****************************************************************
  localparam logic [4:0] IDX_EXT_CAP     = 5'h0F;
  localparam logic [4:0] IDX_LOOPBACK    = 5'h11;
  localparam logic [4:0] IDX_CABLE_TEST  = 5'h12;
  localparam logic [4:0] IDX_LINK_STATUS = 5'h13;
  localparam logic [4:0] IDX_RX_ERR_CNT  = 5'h15;
  localparam logic [4:0] IDX_EVT_STATUS  = 5'h16;
  localparam logic [4:0] IDX_EVT_CLEAR   = 5'h17;
  localparam logic [4:0] IDX_EVT_ENABLE  = 5'h18;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam logic [15:0] EXT_CAP_VALUE   = 16'h3000;
  localparam int          LOOPBACK_BIT    = 8;
  localparam logic [15:0] LOOPBACK_RESET  = 16'h00F4;
  localparam logic [15:0] LOOPBACK_WMASK  = 16'hFFFE;
  localparam int          CT_START_BIT    = 15;
  localparam int          CT_RSV14_BIT    = 14;
  localparam int          CT_PAIR_LSB     = 12;
  localparam int          CT_RSV_LSB      = 10;
  localparam int          CT_FAULT_LSB    = 8;
  localparam int          EVT_RX_ERR_BIT  = 0;
  localparam int          EVT_TEST_DONE   = 1;
  localparam int          EVT_WIDTH       = 2;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [15:0] CNT_RESET       = 16'h0000;

  // ****************************************************************
  // Cable test timing
  // ****************************************************************
  localparam int CLK_MHZ          = 100;
  localparam int TEST_TIME_US     = 10;
  localparam int TEST_CYCLES      = TEST_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    FAULT_NORMAL = 2'h0,
    FAULT_OPEN   = 2'h1,
    FAULT_SHORT  = 2'h2,
    FAULT_RSVD   = 2'h3
  } cable_fault_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic         valid;
    cable_fault_t fault;
  } test_result_t;

endpackage : phy_diag_pkg

/* File: hdl/cable_test_seq.sv */
module cable_test_seq
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       start,
  input  wire logic                       abort,
  input  wire phy_diag_pkg::test_result_t measResult,
  output logic                            busy,
  output logic                            done
);
  import phy_diag_pkg::*;

  typedef enum logic [1:0] {IDLE, RUN, FINISH} seq_state_t;

  seq_state_t  state_ff;
  seq_state_t  nxt_state;
  logic [15:0] timer_ff;

  // ****************************************************************
  // Sequencer: waits for the analog result or the time-out
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      IDLE:
      begin
        if (start)
          nxt_state = RUN;
      end
      RUN:
      begin
        if (abort)
          nxt_state = IDLE;
        else if (measResult.valid || timer_ff == 16'h0000)
          nxt_state = FINISH;
      end
      FINISH:  nxt_state = IDLE;
      default: nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_ff <= IDLE;
    else
      state_ff <= nxt_state;
  end

  // Time-out guards against a measurement that never reports
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timer_ff <= 16'h0000;
    else if (state_ff == IDLE)
      timer_ff <= 16'(TEST_CYCLES - 1);
    else if (timer_ff != 16'h0000)
      timer_ff <= timer_ff - 16'h0001;
  end

  assign busy = (state_ff != IDLE);
  assign done = (state_ff == FINISH);

endmodule : cable_test_seq

/* File: hdl/rx_error_counter.sv */
module rx_error_counter
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        frameError,
  input  wire logic        readClear,
  output logic [15:0]      count
);
  import phy_diag_pkg::*;

  logic [15:0] count_ff;

  // Saturating count; an error in the read cycle restarts at one
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_ff <= CNT_RESET;
    else if (readClear)
      count_ff <= frameError ? 16'h0001 : CNT_RESET;
    else if (frameError && count_ff != CNT_MAX)
      count_ff <= count_ff + 16'h0001;
  end

  assign count = count_ff;

endmodule : rx_error_counter

/* File: hdl/phy_status_diag_registers.sv */
// What this block does
// - Capability bits 13,12 read one
// - Capability bits 15,14 read zero
// - Loopback bit 8 loops received data back
// - Loopback retransmits receive data on transmit
// - Writing start bit one begins test
// - Start bit self-clears when test finishes
// - Start bit reads one while test runs
// - Start reads zero: fault status valid
// - Writing start zero stops the test
// - Bits 13:12 select pair A to D
// - Bits 9:8 report normal, open, short
// - Link status: gigabit bit 1, 100M bit 0
// - Error frame counter increments, clears on read
// - Frame error sets sticky, enabled interrupt flag
module phy_status_diag_registers
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [4:0]                 regAddr,
  input  wire logic [15:0]                regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic [15:0]                     regRdata,
  input  wire logic [7:0]                 rxData,
  input  wire logic                       rxValid,
  input  wire logic [7:0]                 fabricTxData,
  input  wire logic                       fabricTxValid,
  output logic [7:0]                      txData,
  output logic                            txValid,
  output logic                            toFabricValid,
  input  wire logic                       frameSymbolError,
  input  wire logic                       linkUpGig,
  input  wire logic                       linkUp100,
  output logic                            testActive,
  output logic [1:0]                      testPair,
  input  wire phy_diag_pkg::test_result_t measResult,
  output logic                            irq
);
  import phy_diag_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0]          loopback_ff;
  logic                 ctRsv14_ff;
  logic [1:0]           ctPair_ff;
  logic [1:0]           ctRsv_ff;
  cable_fault_t         ctFault_ff;
  logic [EVT_WIDTH-1:0] evtStatus_ff;
  logic [EVT_WIDTH-1:0] evtEnable_ff;
  logic [EVT_WIDTH-1:0] evtSet;
  logic [EVT_WIDTH-1:0] evtClr;
  logic [15:0]          regRdata_ff;
  logic [15:0]          nxt_rdata;
  logic [7:0]           txData_ff;
  logic                 txValid_ff;
  logic [15:0]          errCount;
  logic                 testBusy;
  logic                 testDone;
  logic                 wrCable;
  logic                 cntReadClear;
  logic                 evtReadClear;

  assign wrCable      = regWr && regAddr == IDX_CABLE_TEST;
  assign cntReadClear = regRd && regAddr == IDX_RX_ERR_CNT;
  assign evtReadClear = regRd && regAddr == IDX_EVT_STATUS;

  // ****************************************************************
  // Loopback control register
  // ****************************************************************
  // Bit 0 is read-only zero, so it is masked out of every write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      loopback_ff <= LOOPBACK_RESET;
    else if (regWr && regAddr == IDX_LOOPBACK)
      loopback_ff <= regWdata & LOOPBACK_WMASK;
  end

  // ****************************************************************
  // Line datapath
  // ****************************************************************
  // Loopback takes receive data to transmit; fabric sees nothing
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txData_ff  <= 8'h00;
      txValid_ff <= 1'b0;
    end
    else if (loopback_ff[LOOPBACK_BIT])
    begin
      txData_ff  <= rxData;
      txValid_ff <= rxValid;
    end
    else
    begin
      txData_ff  <= fabricTxData;
      txValid_ff <= fabricTxValid;
    end
  end

  assign txData        = txData_ff;
  assign txValid       = txValid_ff;
  assign toFabricValid = rxValid && !loopback_ff[LOOPBACK_BIT];

  // ****************************************************************
  // Cable test control
  // ****************************************************************
  // Pair select and reserved bits are plain read/write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctRsv14_ff <= 1'b0;
      ctPair_ff  <= 2'h0;
      ctRsv_ff   <= 2'h0;
    end
    else if (wrCable)
    begin
      ctRsv14_ff <= regWdata[CT_RSV14_BIT];
      ctPair_ff  <= regWdata[CT_PAIR_LSB +: 2];
      ctRsv_ff   <= regWdata[CT_RSV_LSB +: 2];
    end
  end

  // Writing zero while running aborts the test
  cable_test_seq u_seq
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .start      (wrCable && regWdata[CT_START_BIT]),
    .abort      (wrCable && !regWdata[CT_START_BIT]),
    .measResult (measResult),
    .busy       (testBusy),
    .done       (testDone)
  );

  assign testActive = testBusy;
  assign testPair   = ctPair_ff;

  // Fault field holds until a measurement result is taken
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctFault_ff <= FAULT_NORMAL;
    else if (testBusy && measResult.valid && !wrCable)
      ctFault_ff <= measResult.fault;
  end

  // ****************************************************************
  // Receive error counter
  // ****************************************************************
  rx_error_counter u_cnt
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .frameError (frameSymbolError),
    .readClear  (cntReadClear),
    .count      (errCount)
  );

  // ****************************************************************
  // Event flags and interrupt
  // ****************************************************************
  assign evtSet[EVT_RX_ERR_BIT] = frameSymbolError;
  assign evtSet[EVT_TEST_DONE]  = testDone;

  // Write clear or read clear; a set in the same cycle wins
  generate
    for (genvar i = 0; i < EVT_WIDTH; i++)
    begin : g_evt
      assign evtClr[i] = (regWr && regAddr == IDX_EVT_CLEAR &&
                          regWdata[i]) || evtReadClear;
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          evtStatus_ff[i] <= 1'b0;
        else if (evtSet[i])
          evtStatus_ff[i] <= 1'b1;
        else if (evtClr[i])
          evtStatus_ff[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      evtEnable_ff <= '0;
    else if (regWr && regAddr == IDX_EVT_ENABLE)
      evtEnable_ff <= regWdata[EVT_WIDTH-1:0];
  end

  assign irq = |(evtStatus_ff & evtEnable_ff);

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped indices read zero
  always_comb
  begin
    nxt_rdata = 16'h0000;
    case (regAddr)
      IDX_EXT_CAP:     nxt_rdata = EXT_CAP_VALUE;
      IDX_LOOPBACK:    nxt_rdata = loopback_ff;
      IDX_CABLE_TEST:
      begin
        nxt_rdata[CT_START_BIT]      = testBusy;
        nxt_rdata[CT_RSV14_BIT]      = ctRsv14_ff;
        nxt_rdata[CT_PAIR_LSB +: 2]  = ctPair_ff;
        nxt_rdata[CT_RSV_LSB +: 2]   = ctRsv_ff;
        nxt_rdata[CT_FAULT_LSB +: 2] = ctFault_ff;
      end
      IDX_LINK_STATUS: nxt_rdata = {14'h0000, linkUpGig, linkUp100};
      IDX_RX_ERR_CNT:  nxt_rdata = errCount;
      IDX_EVT_STATUS:  nxt_rdata = {14'h0000, evtStatus_ff};
      IDX_EVT_ENABLE:  nxt_rdata = {14'h0000, evtEnable_ff};
      default:         nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata_ff <= 16'h0000;
    else if (regRd)
      regRdata_ff <= nxt_rdata;
    else
      regRdata_ff <= 16'h0000;
  end

  assign regRdata = regRdata_ff;

endmodule : phy_status_diag_registers

/* File: sim/phy_status_diag_registers_props.sv */
module phy_status_diag_registers_props
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [4:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic [7:0]  rxData,
  input wire logic        rxValid,
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        toFabricValid,
  input wire logic        frameSymbolError,
  input wire logic        linkUpGig,
  input wire logic        linkUp100,
  input wire logic        testActive,
  input wire logic [1:0]  testPair,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import phy_diag_pkg::*;
  // ****
  // Decoded accesses
  // ****
  // Longest legal run: full time-out plus the finish cycle
  localparam logic [10:0] MaxRun = 11'h3E9;
  logic [10:0] runCnt_ff;
  wire       capRd  = regRd && (regAddr == IDX_EXT_CAP);
  wire       linkRd = regRd && (regAddr == IDX_LINK_STATUS);
  wire       ctRd   = regRd && (regAddr == IDX_CABLE_TEST);
  wire       ctWr   = regWr && (regAddr == IDX_CABLE_TEST);
  wire       looped = rxValid && !toFabricValid;
  wire [1:0] pairIn = regWdata[13:12];
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Counts busy cycles; too long for a delay range, so kept here
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      runCnt_ff <= 11'h000;
    else if (testActive)
      runCnt_ff <= runCnt_ff + 11'h001;
    else
      runCnt_ff <= 11'h000;
  end
  // Read data stands the cycle after the strobe
  a_cap_fixed: assert property ($past(capRd) |->
    regRdata == 16'h3000) else $error("capability read wrong");
  a_link_live: assert property ($past(linkRd) |->
    regRdata == {14'h0, $past(linkUpGig), $past(linkUp100)})
    else $error("link status read wrong");
  a_loop_echo: assert property (looped |=>
    txValid && txData == $past(rxData)) else $error("loopback lost");
  a_start_runs: assert property (ctWr && regWdata[15] && !testActive
    |=> testActive) else $error("test did not start");
  a_stop_idles: assert property (ctWr && !regWdata[15]
    |=> !testActive) else $error("test did not stop");
  // The timeout guards a hang when no result arrives
  a_run_bounded: assert property (testActive |->
    runCnt_ff < MaxRun) else $error("test never ended");
  a_busy_reads: assert property ($past(ctRd) |->
    regRdata[15] == $past(testActive)) else $error("start bit wrong");
  a_pair_taken: assert property (ctWr |=>
    testPair == $past(pairIn)) else $error("pair not taken");
  a_irq_cause: assert property ($rose(irq) |->
    $past(frameSymbolError) || $past(regWr) || $past(testActive)
    || $past(testActive, 2)) else $error("irq without event");
  c_test: cover property ($rose(testActive));
  c_loop: cover property (looped);
  c_irq: cover property ($rose(irq));
endmodule : phy_status_diag_registers_props

/* File: sim/phy_status_diag_registers_tb.sv */
module phy_status_diag_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_diag_pkg::*;
  // ****
  // Bench signals and model state
  // ****
  logic         clk, reset_n, regWr, regRd, rxValid, fabricTxValid;
  logic         txValid, toFabricValid, frameSymbolError, linkUpGig;
  logic         linkUp100, testActive, irq;
  logic [1:0]   testPair, p, f, lastFault;
  logic [4:0]   regAddr;
  logic [7:0]   rxData, fabricTxData, txData;
  logic [7:0]   txq[$];
  logic [15:0]  regWdata, regRdata, rdv, expv;
  test_result_t measResult;
  int           num_errors, compares, seed, errCount, k;

  phy_status_diag_registers dut
  (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxData(rxData),
    .rxValid(rxValid), .fabricTxData(fabricTxData),
    .fabricTxValid(fabricTxValid), .txData(txData), .txValid(txValid),
    .toFabricValid(toFabricValid), .frameSymbolError(frameSymbolError),
    .linkUpGig(linkUpGig), .linkUp100(linkUp100), .testActive(testActive),
    .testPair(testPair), .measResult(measResult), .irq(irq)
  );

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // Data only stand one cycle, so sample once the edge has settled
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    rd(a, rdv);
    chk(rdv, e);
  endtask : rdchk

  // Gaps keep each pulse a separate frame
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk);
      frameSymbolError <= 1'b1;
      @(posedge clk);
      frameSymbolError <= 1'b0;
    end
  endtask : pulse

  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, {15'h0, e});
  endtask : irqchk

  task automatic final_report;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Watchdog: the run needs about 70k cycles
  initial
  begin
    #900000;
    num_errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    seed = 32'he0f48907;
    {reset_n, regWr, regRd, rxValid, fabricTxValid, frameSymbolError} = '0;
    {linkUpGig, linkUp100, regAddr, regWdata, rxData, fabricTxData} = '0;
    measResult = '0;
    lastFault = 2'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(IDX_EXT_CAP, 16'h3000);
    wr(IDX_EXT_CAP, 16'hFFFF);
    rdchk(IDX_EXT_CAP, 16'h3000);
    rdchk(5'h00, 16'h0000);
    rdchk(IDX_LOOPBACK, LOOPBACK_RESET);
    $display("test fixed values done");
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      linkUpGig <= k[1];
      linkUp100 <= k[0];
      rdchk(IDX_LINK_STATUS, 16'(k));
    end
    $display("test link status done");
    // Loopback on, then off; fabric data must not leak into loopback
    for (int m = 1; m >= 0; m--)
    begin
      wr(IDX_LOOPBACK, m ? 16'h01F4 : 16'h00F4);
      rdchk(IDX_LOOPBACK, m ? 16'h01F4 : 16'h00F4);
      txq.delete();
      for (k = 0; k < 20; k++)
      begin
        @(posedge clk);
        rxValid <= 1'b1;
        fabricTxValid <= 1'b1;
        rxData <= 8'($random(seed));
        fabricTxData <= 8'($random(seed));
        #1;
        if (k > 0)
        begin
          expv = {6'h0, ~m[0], 1'b1, txq.pop_front()};
          chk({6'h0, toFabricValid, txValid, txData}, expv);
        end
        txq.push_back(m ? rxData : fabricTxData);
      end
      rxValid <= 1'b0;
      fabricTxValid <= 1'b0;
    end
    $display("test loopback done");
    // All pairs meet normal, open and short across the twelve runs
    for (k = 0; k < 12; k++)
    begin
      p = 2'(k % 4);
      f = 2'(k % 3);
      wr(IDX_CABLE_TEST, {2'b10, p, 12'h000});
      rdchk(IDX_CABLE_TEST, {2'b10, p, 2'b00, lastFault, 8'h00});
      chk({14'h0, testPair}, {14'h0, p});
      repeat (($random(seed) & 15) + 1) @(posedge clk);
      measResult <= '{1'b1, cable_fault_t'(f)};
      @(posedge clk);
      measResult <= '0;
      rdv = 16'hFFFF;
      for (int i = 0; i < 20 && rdv[15]; i++) rd(IDX_CABLE_TEST, rdv);
      chk(rdv, {2'b00, p, 2'b00, f, 8'h00});
      lastFault = f;
    end
    $display("test cable runs done");
    wr(IDX_CABLE_TEST, 16'hA000);
    repeat (3) @(posedge clk);
    wr(IDX_CABLE_TEST, 16'h1000);
    rdchk(IDX_CABLE_TEST, {4'h1, 2'b00, lastFault, 8'h00});
    $display("test abort done");
    rdchk(IDX_EVT_STATUS, 16'h0002);
    wr(IDX_EVT_ENABLE, 16'h0000);
    errCount = ($random(seed) & 15) + 1;
    pulse(errCount);
    irqchk(1'b0);
    rdchk(IDX_EVT_STATUS, 16'h0001);
    rdchk(IDX_RX_ERR_CNT, 16'(errCount));
    rdchk(IDX_RX_ERR_CNT, 16'h0000);
    wr(IDX_EVT_ENABLE, 16'h0001);
    pulse(1);
    irqchk(1'b1);
    rd(IDX_EVT_STATUS, rdv);
    irqchk(1'b0);
    pulse(1);
    irqchk(1'b1);
    wr(IDX_EVT_CLEAR, 16'h0001);
    irqchk(1'b0);
    $display("test events done");
    // One errored frame per cycle drives the count past its top
    rd(IDX_RX_ERR_CNT, rdv);
    @(posedge clk);
    frameSymbolError <= 1'b1;
    repeat (65540) @(posedge clk);
    frameSymbolError <= 1'b0;
    rdchk(IDX_RX_ERR_CNT, 16'hFFFF);
    $display("test saturation done");
    final_report();
  end
endmodule : phy_status_diag_registers_tb

bind phy_status_diag_registers phy_status_diag_registers_props props
(
  .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxData(rxData),
  .rxValid(rxValid), .txData(txData), .txValid(txValid),
  .toFabricValid(toFabricValid), .frameSymbolError(frameSymbolError),
  .linkUpGig(linkUpGig), .linkUp100(linkUp100), .testActive(testActive),
  .testPair(testPair), .irq(irq)
);
